// ### exec_consts.svh
`ifndef EXEC_CONSTS_SVH
`define EXEC_CONSTS_SVH

// ****************************************************************
// Register map, word addresses on the plain register port
// ****************************************************************
`define ADDR_CMD        8'h00
`define ADDR_ACC        8'h01
`define ADDR_STATUS     8'h02
`define ADDR_CONFIG     8'h03
`define ADDR_PC         8'h04
`define ADDR_STACK_TOP  8'h05
`define ADDR_WATCHDOG   8'h06
`define ADDR_STATE      8'h07
`define ADDR_FILE_BASE  8'h20
`define ADDR_FILE_MASK  8'hE0

// ****************************************************************
// Instruction word fields written to the command register
// ****************************************************************
`define INS_LIT_LSB     0
`define INS_LIT_MSB     7
`define INS_FIDX_LSB    8
`define INS_FIDX_MSB    12
`define INS_DEST_BIT    13
`define INS_OP_LSB      16
`define INS_OP_MSB      18

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define ST_CARRY_BIT    0
`define ST_DC_BIT       1
`define ST_ZERO_BIT     2
`define ST_PD_BIT       3
`define ST_TO_BIT       4
`define ST_WAKE_BIT     7

// ****************************************************************
// Reset values and widths
// ****************************************************************
`define ACC_RST         8'h00
`define CONFIG_RST      8'hFF
`define PC_RST          11'h000
`define STACK_TOP_RST   11'h000
`define WDOG_RST        8'h00
`define PRESC_RST       8'h00
`define PRESC_MAX       8'hFF
`define FILE_RST        8'h00
`define FILE_COUNT      32
`define PC_STEP         11'h001

`endif

// ### exec_pkg.sv
`default_nettype none

package exec_pkg;

  // Opcodes carried in the instruction word
  typedef enum logic [2:0] {
    OP_NO_OP      = 3'h0,
    OP_LOAD_LIT   = 3'h1,
    OP_LOAD_CFG   = 3'h2,
    OP_RET_LIT    = 3'h3,
    OP_POWER_DOWN = 3'h4,
    OP_ROTATE_L   = 3'h5,
    OP_SUBTRACT   = 3'h6,
    OP_SPARE      = 3'h7
  } opcode_t;

  // Core sequencing state
  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_FLUSH = 2'h1,
    ST_SLEEP = 2'h2
  } core_state_t;

endpackage

`default_nettype wire

// ### alu_if.sv
`timescale 1ns/100ps
`default_nettype none

// Operands and results between the core and its arithmetic unit
interface alu_if;
  logic [7:0] file_val;
  logic [7:0] acc_val;
  logic       carry_in;
  logic       sel_sub;
  logic [7:0] result;
  logic       carry_out;
  logic       dc_out;
  logic       zero_out;

  modport core (output file_val, acc_val, carry_in, sel_sub,
                input  result, carry_out, dc_out, zero_out);
  modport alu  (input  file_val, acc_val, carry_in, sel_sub,
                output result, carry_out, dc_out, zero_out);
endinterface

`default_nettype wire

// ### exec_alu.sv
`timescale 1ns/100ps
`default_nettype none

module exec_alu
  import exec_pkg::*;
(
  alu_if.alu a
);

  logic [8:0] diff_full;
  logic [4:0] diff_low;

  // ****************************************************************
  // Subtract by adding the inverted accumulator plus one
  // ****************************************************************
  // Carry out of the sum is the no-borrow indication directly
  assign diff_full = {1'b0, a.file_val} + {1'b0, ~a.acc_val} + 9'h001;
  assign diff_low  = {1'b0, a.file_val[3:0]} + {1'b0, ~a.acc_val[3:0]} + 5'h01;

  // Result and flag selection between subtract and rotate
  always_comb
  begin
    if (a.sel_sub)
    begin
      a.result    = diff_full[7:0];
      a.carry_out = diff_full[8];
      a.dc_out    = diff_low[4];
    end
    else
    begin
      a.result    = {a.file_val[6:0], a.carry_in};
      a.carry_out = a.file_val[7];
      a.dc_out    = 1'b0;
    end
    a.zero_out = (a.result == 8'h00);
  end

endmodule // exec_alu

`default_nettype wire

// ### exec_core.sv
// Contract
// - Load-literal puts its 8-bit literal into the accumulator and leaves all flags alone.
// - Configuration-load copies the accumulator into the configuration register, flags kept.
// - Return-with-literal loads the literal into the accumulator and the PC from stack top.
// - Return-with-literal takes two instruction cycles, the fetched follower being dropped.
// - Power-down clears the watchdog counter and the watchdog prescaler.
// - Power-down sets the timeout flag and leaves the pin-change wake flag as it was.
// - Power-down clears the power-down flag.
// - After power-down the core halts with its oscillator stopped until a wake source.
// - Rotate-left shifts file register 0..31 left through carry, only carry changing.
// - Destination bit 0 sends the result to the accumulator, 1 back to the file register.
// - Subtract computes file minus accumulator in two's complement and updates C, DC, Z.
//
// Implementation choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "exec_consts.svh"

module exec_core
  import exec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        wake_in,
  output logic      [31:0] rdata,
  output logic      [7:0]  config_out,
  output logic             osc_run,
  output logic             busy
);

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  // Used for both write and read paths
  function automatic logic file_hit(input logic [7:0] a);
    file_hit = ((a & `ADDR_FILE_MASK) == `ADDR_FILE_BASE);
  endfunction

  core_state_t state_q;
  logic [7:0]  acc_q;
  logic [7:0]  config_q;
  logic [10:0] pc_q;
  logic [10:0] stack_top_q;
  logic [7:0]  watchdog_counter_q;
  logic [7:0]  presc_q;
  logic        carry_q;
  logic        digit_carry_flag_q;
  logic        zero_q;
  logic        timeout_flag_q;
  logic        powerdown_flag_q;
  logic        pin_change_wake_flag_q;
  logic [31:0] rdata_q;
  logic [7:0]  file_q [`FILE_COUNT];

  opcode_t     op;
  logic [4:0]  fidx;
  logic [7:0]  lit;
  logic        dest_file;
  logic        cmd_go;
  logic        alu_op;
  logic        res_to_acc;
  logic        res_to_file;
  logic        wr_status;
  logic        wake_go;

  alu_if alu_bus ();

  // ****************************************************************
  // Instruction issue
  // ****************************************************************
  // Commands are taken only while running; command writes in flush or sleep are dropped
  assign op        = opcode_t'(wdata[`INS_OP_MSB:`INS_OP_LSB]);
  assign fidx      = wdata[`INS_FIDX_MSB:`INS_FIDX_LSB];
  assign lit       = wdata[`INS_LIT_MSB:`INS_LIT_LSB];
  assign dest_file = wdata[`INS_DEST_BIT];
  assign cmd_go    = wr && (addr == `ADDR_CMD) && (state_q == ST_RUN);
  assign alu_op    = (op == OP_ROTATE_L) || (op == OP_SUBTRACT);
  assign res_to_acc  = cmd_go && alu_op && !dest_file;
  assign res_to_file = cmd_go && alu_op && dest_file;
  assign wr_status = wr && (addr == `ADDR_STATUS);
  assign wake_go   = (state_q == ST_SLEEP) && wake_in;

  // Operands for the arithmetic unit
  assign alu_bus.file_val = file_q[fidx];
  assign alu_bus.acc_val  = acc_q;
  assign alu_bus.carry_in = carry_q;
  assign alu_bus.sel_sub  = (op == OP_SUBTRACT);

  exec_alu u_alu (
    .a (alu_bus)
  );

  // ****************************************************************
  // Sequencing state
  // ****************************************************************
  // Flush spends the second cycle of a return; sleep holds until wake
  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= ST_RUN;
    else
    begin
      unique case (state_q)
        ST_RUN:
        begin
          if (cmd_go && op == OP_RET_LIT)
            state_q <= ST_FLUSH;
          else if (cmd_go && op == OP_POWER_DOWN)
            state_q <= ST_SLEEP;
        end
        ST_FLUSH:
          state_q <= ST_RUN;
        ST_SLEEP:
        begin
          if (wake_in)
            state_q <= ST_RUN;
        end
        default:
          state_q <= ST_RUN;
      endcase
    end
  end

  assign busy    = (state_q != ST_RUN);
  assign osc_run = (state_q != ST_SLEEP);

  // ****************************************************************
  // Accumulator
  // ****************************************************************
  // Bus writes land only when no instruction is issued in that cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      acc_q <= `ACC_RST;
    else if (cmd_go && (op == OP_LOAD_LIT || op == OP_RET_LIT))
      acc_q <= lit;
    else if (res_to_acc)
      acc_q <= alu_bus.result;
    else if (wr && addr == `ADDR_ACC)
      acc_q <= wdata[7:0];
  end

  // Configuration register, output straight from its flop
  always_ff @(posedge clk)
  begin
    if (rst)
      config_q <= `CONFIG_RST;
    else if (cmd_go && op == OP_LOAD_CFG)
      config_q <= acc_q;
    else if (wr && addr == `ADDR_CONFIG)
      config_q <= wdata[7:0];
  end

  assign config_out = config_q;

  // ****************************************************************
  // Program counter and stack top
  // ****************************************************************
  // Every taken instruction advances the PC except a return
  always_ff @(posedge clk)
  begin
    if (rst)
      pc_q <= `PC_RST;
    else if (cmd_go && op == OP_RET_LIT)
      pc_q <= stack_top_q;
    else if (cmd_go)
      pc_q <= pc_q + `PC_STEP;
  end

  // Stack top is loaded from the bus so calls can be staged
  always_ff @(posedge clk)
  begin
    if (rst)
      stack_top_q <= `STACK_TOP_RST;
    else if (wr && addr == `ADDR_STACK_TOP)
      stack_top_q <= wdata[10:0];
  end

  // ****************************************************************
  // Arithmetic flags
  // ****************************************************************
  // Literal, config, return and no-op leave these untouched
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      carry_q            <= 1'b0;
      digit_carry_flag_q <= 1'b0;
      zero_q             <= 1'b0;
    end
    else if (cmd_go && op == OP_SUBTRACT)
    begin
      carry_q            <= alu_bus.carry_out;
      digit_carry_flag_q <= alu_bus.dc_out;
      zero_q             <= alu_bus.zero_out;
    end
    else if (cmd_go && op == OP_ROTATE_L)
      carry_q <= alu_bus.carry_out;
    else if (wr_status)
    begin
      carry_q            <= wdata[`ST_CARRY_BIT];
      digit_carry_flag_q <= wdata[`ST_DC_BIT];
      zero_q             <= wdata[`ST_ZERO_BIT];
    end
  end

  // ****************************************************************
  // Power-state flags
  // ****************************************************************
  // Both read as one after reset; only power-down moves them here
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      timeout_flag_q   <= 1'b1;
      powerdown_flag_q <= 1'b1;
    end
    else if (cmd_go && op == OP_POWER_DOWN)
    begin
      timeout_flag_q   <= 1'b1;
      powerdown_flag_q <= 1'b0;
    end
  end

  // Wake flag: set by a wake from sleep, cleared by software; set wins
  always_ff @(posedge clk)
  begin
    if (rst)
      pin_change_wake_flag_q <= 1'b0;
    else if (wake_go)
      pin_change_wake_flag_q <= 1'b1;
    else if (wr_status)
      pin_change_wake_flag_q <= pin_change_wake_flag_q & wdata[`ST_WAKE_BIT];
    // Power-down itself leaves this flag as it was
  end

  // ****************************************************************
  // Watchdog counter and prescaler
  // ****************************************************************
  // Frozen in sleep because the oscillator is stopped there
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      presc_q            <= `PRESC_RST;
      watchdog_counter_q <= `WDOG_RST;
    end
    else if (cmd_go && op == OP_POWER_DOWN)
    begin
      presc_q            <= `PRESC_RST;
      watchdog_counter_q <= `WDOG_RST;
    end
    else if (state_q != ST_SLEEP)
    begin
      presc_q <= presc_q + 8'h01;
      if (presc_q == `PRESC_MAX)
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
    end
  end

  // ****************************************************************
  // File registers
  // ****************************************************************
  // One flop group per register; the instruction and the bus never
  // write in the same cycle because strobes are exclusive
  for (genvar i = 0; i < `FILE_COUNT; i++)
  begin : g_file
    always_ff @(posedge clk)
    begin
      if (rst)
        file_q[i] <= `FILE_RST;
      else if (res_to_file && fidx == 5'(i))
        file_q[i] <= alu_bus.result;
      else if (wr && file_hit(addr) && addr[4:0] == 5'(i))
        file_q[i] <= wdata[7:0];
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  // Data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk)
  begin
    if (rst || !rd)
      rdata_q <= 32'h0000_0000;
    else if (file_hit(addr))
      rdata_q <= {24'h00_0000, file_q[addr[4:0]]};
    else
    begin
      unique case (addr)
        `ADDR_ACC:       rdata_q <= {24'h00_0000, acc_q};
        `ADDR_STATUS:    rdata_q <= {24'h00_0000, pin_change_wake_flag_q, 2'h0,
                                     timeout_flag_q, powerdown_flag_q, zero_q,
                                     digit_carry_flag_q, carry_q};
        `ADDR_CONFIG:    rdata_q <= {24'h00_0000, config_q};
        `ADDR_PC:        rdata_q <= {21'h00_0000, pc_q};
        `ADDR_STACK_TOP: rdata_q <= {21'h00_0000, stack_top_q};
        `ADDR_WATCHDOG:  rdata_q <= {16'h0000, watchdog_counter_q, presc_q};
        `ADDR_STATE:     rdata_q <= {30'h0000_0000, state_q};
        default:         rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata = rdata_q;

endmodule // exec_core

`default_nettype wire

// ### exec_core_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_consts.svh"

module exec_core_props
  import exec_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        wake_in,
  input wire logic [31:0] rdata,
  input wire logic [7:0]  config_out,
  input wire logic        osc_run,
  input wire logic        busy
);
  // ****************************************************************
  // Instruction acceptance and checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Commands only count when the core is able to take them
  logic       cmd;
  logic [2:0] op;
  assign cmd = wr && (addr == `ADDR_CMD) && !busy;
  assign op  = wdata[`INS_OP_MSB:`INS_OP_LSB];

  AST_RD_IDLE_ZERO: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  AST_RET_FLUSH: assert property (cmd && op == OP_RET_LIT |=> busy ##1 !busy)
    else $error("return did not take exactly two cycles");
  AST_NOP_ONE: assert property (cmd && op == OP_NO_OP |=> !busy && osc_run)
    else $error("no-op did not complete in one cycle");
  AST_SLEEP_ENTRY: assert property (cmd && op == OP_POWER_DOWN |=> !osc_run && busy)
    else $error("power-down did not stop the oscillator");
  AST_SLEEP_HOLD: assert property (!osc_run && !wake_in |=> !osc_run)
    else $error("left sleep without a wake source");
  AST_WAKE_RUN: assert property (!osc_run && wake_in |=> osc_run && !busy)
    else $error("wake source did not restart the core");
  AST_CFG_STABLE: assert property (
    !(wr && (addr == `ADDR_CMD || addr == `ADDR_CONFIG)) |=> $stable(config_out))
    else $error("configuration changed without a cause");
  AST_CFG_WRITE: assert property (
    wr && addr == `ADDR_CONFIG |=> config_out == $past(wdata[7:0]))
    else $error("configuration write not applied");
  AST_SLEEP_STATUS: assert property (
    rd && addr == `ADDR_STATUS && !osc_run
    |=> {rdata[`ST_TO_BIT], rdata[`ST_PD_BIT]} == 2'b10)
    else $error("sleep status flags wrong");
  AST_SLEEP_WDOG: assert property (
    rd && addr == `ADDR_WATCHDOG && !osc_run |=> rdata[15:0] == 16'h0000)
    else $error("watchdog not cleared in sleep");

  // Main scenarios seen at least once
  COV_RET: cover property (cmd && op == OP_RET_LIT);
  COV_SLEEP: cover property (cmd && op == OP_POWER_DOWN);
  COV_WAKE: cover property (!osc_run && wake_in);
endmodule // exec_core_props

bind exec_core exec_core_props u_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .wake_in(wake_in), .rdata(rdata), .config_out(config_out),
  .osc_run(osc_run), .busy(busy));

`default_nettype wire

// ### tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "exec_consts.svh"

module tb
  import exec_pkg::*;
;
  // ****************************************************************
  // Stimulus, model and checks
  // ****************************************************************
  logic        clk, rst, wr, rd, wake_in, osc_run, busy, busy_seen;
  logic [7:0]  addr, config_out, m_acc, m_cfg;
  logic [7:0]  m_f [32];
  logic [31:0] wdata, rdata, q, seed, t, u;
  logic        m_c, m_dc, m_z, m_pd, m_to, m_wk;
  logic [10:0] m_pc, m_st;
  int          n_errors, num_checks, i;

  exec_core dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .wake_in(wake_in), .rdata(rdata), .config_out(config_out), .osc_run(osc_run),
    .busy(busy));

  // Free-running 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // One bus cycle, then an idle cycle so a return's flush cycle is respected
  task automatic bus(logic w, logic r, logic [7:0] a, logic [31:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
    busy_seen = busy;
    @(posedge clk);
  endtask

  task automatic rchk(string n, logic [7:0] a, logic [31:0] e);
    bus(1'b0, 1'b1, a, 32'h0);
    chk(n, e, q);
  endtask

  task automatic check_state(int k);
    rchk("acc", `ADDR_ACC, {24'h0, m_acc});
    bus(1'b0, 1'b1, `ADDR_STATUS, 32'h0);
    chk("status", {24'h0, m_wk, 2'b00, m_to, m_pd, m_z, m_dc, m_c}, q);
    rchk("config", `ADDR_CONFIG, {24'h0, m_cfg});
    chk("config_out", {24'h0, m_cfg}, {24'h0, config_out});
    rchk("pc", `ADDR_PC, {21'h0, m_pc});
    rchk("stack_top", `ADDR_STACK_TOP, {21'h0, m_st});
    rchk("file", 8'(`ADDR_FILE_BASE + k), {24'h0, m_f[k]});
  endtask

  // Issue one instruction and update the reference model
  task automatic run(logic [2:0] op, int k, logic d, logic [7:0] lit);
    logic [7:0] f, r;
    f = m_f[k];
    r = f;
    bus(1'b1, 1'b0, `ADDR_CMD, {13'h0, op, 2'b00, d, 5'(k), lit});
    // Only a return (flush) or a power-down leaves the core busy after the command
    chk("busy", 32'(op == OP_RET_LIT || op == OP_POWER_DOWN), 32'(busy_seen));
    m_pc = (op == OP_RET_LIT) ? m_st : m_pc + 11'h001;
    case (op)
      OP_LOAD_LIT: m_acc = lit;
      OP_LOAD_CFG: m_cfg = m_acc;
      OP_RET_LIT: m_acc = lit;
      OP_POWER_DOWN: {m_to, m_pd} = 2'b10;
      OP_ROTATE_L: {m_c, r} = {f, m_c};
      OP_SUBTRACT:
      begin
        r = f - m_acc;
        m_c = f >= m_acc;
        m_dc = f[3:0] >= m_acc[3:0];
        m_z = r == 8'h00;
      end
      default: ;
    endcase
    if (op == OP_ROTATE_L || op == OP_SUBTRACT)
    begin
      if (d)
        m_f[k] = r;
      else
        m_acc = r;
    end
    check_state(k);
  endtask

  // Sleep, try a dropped command, then wake after a random pause
  task automatic sleep_wake(int pause);
    run(OP_POWER_DOWN, 0, 1'b0, 8'h00);
    rchk("watchdog", `ADDR_WATCHDOG, 32'h0);
    rchk("state", `ADDR_STATE, {30'h0, ST_SLEEP});
    bus(1'b1, 1'b0, `ADDR_CMD, {13'h0, OP_LOAD_LIT, 2'b00, 1'b0, 5'h00, 8'hA5});
    repeat (pause) @(posedge clk);
    @(negedge clk);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    chk("busy", 32'h1, {31'h0, busy});
    @(posedge clk);
    wake_in <= 1'b1;
    @(posedge clk);
    wake_in <= 1'b0;
    @(negedge clk);
    m_wk = 1'b1;
    chk("osc_run", 32'h1, {31'h0, osc_run});
    chk("busy", 32'h0, {31'h0, busy});
    @(posedge clk);
    check_state(0);
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog: the whole run needs well under this span
  initial
  begin
    #400000;
    n_errors++;
    report_and_stop();
  end

  initial
  begin
    {rst, wr, rd, wake_in, addr, wdata} = {4'h8, 8'h00, 32'h0};
    seed = 32'h52317DED;
    n_errors = 0;
    num_checks = 0;
    {m_acc, m_cfg, m_c, m_dc, m_z, m_pd, m_to, m_wk} = {16'h00FF, 6'h06};
    {m_pc, m_st} = 22'h0;
    foreach (m_f[j]) m_f[j] = 8'h00;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_state(31);
    rchk("unmapped", 8'h10, 32'h0);
    bus(1'b1, 1'b0, 8'h10, 32'hFFFFFFFF);
    check_state(0);
    // Random operands and every opcode, with random preloads
    for (int n = 0; n < 300; n++)
    begin
      t = rnd();
      u = rnd();
      i = int'(t[20:16]);
      if (t[3])
      begin
        bus(1'b1, 1'b0, `ADDR_ACC, {24'h0, t[15:8]});
        m_acc = t[15:8];
      end
      if (t[4])
      begin
        bus(1'b1, 1'b0, 8'(`ADDR_FILE_BASE + i), {24'h0, t[31:24]});
        m_f[i] = t[31:24];
      end
      if (t[5])
      begin
        bus(1'b1, 1'b0, `ADDR_STACK_TOP, {21'h0, t[31:21]});
        m_st = t[31:21];
      end
      if (t[6])
      begin
        bus(1'b1, 1'b0, `ADDR_STATUS, {24'h0, t[7:0]});
        {m_z, m_dc, m_c} = t[2:0];
        m_wk &= t[7];
      end
      if (u[2:0] == OP_POWER_DOWN)
        sleep_wake(int'(u[12:5]));
      else
        run(u[2:0], i, u[3], u[15:8]);
    end
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
